// [rtl/service_data_logger.sv]
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "service_data_logger_defs.svh"
module service_data_logger
  import sdl_pkg::*;
#(
  // cycles per 1 ms time base
  parameter int TICK_CYCLES = `SDL_MS_NS / `SDL_CLK_NS,
  // ms per tenth of an hour
  parameter int TENTH_MS = `SDL_TENTH_MS,
  // ms between snapshots
  parameter int SNAP_MS = `SDL_SNAP_MS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // drive status
  input wire logic converterOn,
  input wire logic motorRunning,
  input wire logic supplyApplied,
  input wire logic powerFail,
  input wire logic overtempEvent,
  input wire logic overvoltEvent,
  input wire logic overvoltAlarm,
  input wire logic [15:0] outputPower,
  // snapshot sources
  input wire logic startCmd,
  input wire logic [7:0] terminalIn,
  input wire logic [15:0] stateWord,
  // trips
  input wire logic tripEvent,
  input wire logic [6:0] tripCode,
  input wire logic [15:0] tripValue,
  // operator panel
  input wire logic energyClearSelect,
  input wire logic runClearSelect,
  input wire logic panelOk,
  input wire logic manualInit,
  // outputs to the drive
  output logic [15:0] driveControlWord,
  output logic persistStrobe
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int MW = $clog2(TENTH_MS);
  localparam int SW = $clog2(SNAP_MS + 1);
  localparam logic [20:0] HOURS_MAX = 21'(`SDL_HOURS_MAX);
  localparam logic [13:0] EVT_MAX = 14'(`SDL_EVT_MAX);
  // one kWh in watt-ms over the hour as TENTH_MS makes it, so a shortened hour still counts energy
  localparam logic [39:0] KWH = 40'(`SDL_W_PER_KW) * 40'(`SDL_TENTHS_PER_HOUR + 1) * 40'(TENTH_MS);

  // whole module state
  typedef struct packed {
    logic [TW-1:0] tick;        // 1 ms prescaler
    logic [MW-1:0] wallMs;      // wall clock within a tenth hour
    logic [3:0] wallTenth;      // tenths within the hour
    logic [MW-1:0] opMs;        // operating time within a tenth
    logic [MW-1:0] runMs;       // running time within a tenth
    logic [SW-1:0] snapMs;      // time since last snapshot
    logic [20:0] opHours;       // tenths of an hour
    logic [20:0] runHours;      // tenths of an hour
    logic [31:0] energy;        // whole kWh
    logic [39:0] hourSum;       // watt-ms in the current hour
    logic [39:0] residue;       // watt-ms not yet counted as kWh
    logic [13:0] cutIns;
    logic [13:0] overTemps;
    logic [13:0] overVolts;
    logic [15:0] ctrl;          // drive control word
    logic [4:0] snapIdx;
    logic [3:0] faultIdx;
    logic motorPrev;
    logic failPrev;
    logic persist;
    snap_state_t snap;
    logic aValid;               // data phase pending
    logic aWrite;
    logic [5:0] aAddr;
    logic [1:0] rdCnt;          // read wait counter
    logic [31:0] rdata;
  } state_t;
  localparam state_t RESET_STATE = '{snap: SNAP_IDLE, default: '0};

  state_t s_q, s_d;
  logic tickNow;         // last cycle of a 1 ms period
  logic hourEnd;         // last cycle of the wall-clock hour
  logic motorStop;       // running fell this cycle
  logic snapWr;          // push one snapshot entry
  logic energyClr;
  logic runClr;
  logic busWr;           // write data phase
  logic drain;           // one kWh ready to count
  logic [7:0] loggedInputBits;
  logic [13:0] valClamp;
  logic [6:0] codeClamp;
  logic [31:0] rdMux;
  snap_entry_t snapIn, snapOut;
  fault_entry_t faultIn, faultOut;
  logic [4:0] snapFill;
  logic [3:0] faultFill;

  // true when a data-phase word address matches a byte offset
  function automatic logic hit(input logic [5:0] a, input logic [7:0] off);
    return a == off[7:2];
  endfunction

  // saturating event counter step
  function automatic logic [13:0] bump(input logic [13:0] c, input logic ev);
    return (ev && c < EVT_MAX) ? c + 14'h0001 : c;
  endfunction

  // terminal 16 on bit 7 down to terminal 33 on bit 0
  for (genvar g = 0; g < 8; g++)
  begin : g_inputs
    assign loggedInputBits[7-g] = terminalIn[g];
  end

  // strobes
  assign tickNow = s_q.tick == TW'(TICK_CYCLES - 1);
  assign hourEnd = tickNow && s_q.wallMs == MW'(TENTH_MS - 1)
    && s_q.wallTenth == 4'(`SDL_TENTHS_PER_HOUR);
  assign motorStop = s_q.motorPrev && !motorRunning;
  assign snapWr = s_q.snap == SNAP_RUN && tickNow && s_q.snapMs == SW'(SNAP_MS - 1)
    && !tripEvent && !motorStop;
  // clears come only from the panel; the bus has no path to them
  assign energyClr = panelOk && energyClearSelect;
  assign runClr = panelOk && runClearSelect;
  assign busWr = s_q.aValid && s_q.aWrite;
  assign drain = s_q.residue >= KWH;

  // trip figures clamped into their documented ranges
  assign codeClamp = (tripCode > 7'(`SDL_CODE_MAX)) ? 7'(`SDL_CODE_MAX) : tripCode;
  assign valClamp = (tripValue > 16'(`SDL_EVT_MAX)) ? EVT_MAX : tripValue[13:0];

  // entries for the two histories
  assign snapIn = '{loggedInputBits: loggedInputBits, controlWord: s_q.ctrl,
    loggedStateWord: stateWord};
  assign faultIn = '{code: codeClamp, value: valClamp, runHours: s_q.runHours};

  // snapshot history, newest first
  log_memory #(
    .WIDTH($bits(snap_entry_t)),
    .DEPTH(`SDL_SNAP_DEPTH),
    .AW(5)
  ) snapMem (
    .clk(clk),
    .reset(reset),
    .clear(1'b0),
    .wrEn(snapWr),
    .wrData(snapIn),
    .rdIndex(s_q.snapIdx),
    .rdData(snapOut),
    .fill(snapFill)
  );

  // fault history; only the initialisation input empties it
  log_memory #(
    .WIDTH($bits(fault_entry_t)),
    .DEPTH(`SDL_FAULT_DEPTH),
    .AW(4)
  ) faultMem (
    .clk(clk),
    .reset(reset),
    .clear(manualInit),
    .wrEn(tripEvent),
    .wrData(faultIn),
    .rdIndex(s_q.faultIdx),
    .rdData(faultOut),
    .fill(faultFill)
  );

  // read data selection
  always_comb
  begin
    rdMux = '0;
    case (1'b1)
      hit(s_q.aAddr, `SDL_A_OPHOURS): rdMux = {11'h000, s_q.opHours};
      hit(s_q.aAddr, `SDL_A_RUNHOURS): rdMux = {11'h000, s_q.runHours};
      hit(s_q.aAddr, `SDL_A_ENERGY): rdMux = s_q.energy;
      hit(s_q.aAddr, `SDL_A_CUTINS): rdMux = {18'h00000, s_q.cutIns};
      hit(s_q.aAddr, `SDL_A_OVERTEMPS): rdMux = {18'h00000, s_q.overTemps};
      hit(s_q.aAddr, `SDL_A_OVERVOLTS): rdMux = {18'h00000, s_q.overVolts};
      hit(s_q.aAddr, `SDL_A_CTRL): rdMux = {16'h0000, s_q.ctrl};
      hit(s_q.aAddr, `SDL_A_INDEX): rdMux = {20'h00000, s_q.faultIdx, 3'h0, s_q.snapIdx};
      // 16-bit words, plain unsigned
      hit(s_q.aAddr, `SDL_A_SNAPWORDS):
        rdMux = {snapOut.controlWord, snapOut.loggedStateWord};
      hit(s_q.aAddr, `SDL_A_SNAPINPUTS): rdMux = {24'h000000, snapOut.loggedInputBits};
      hit(s_q.aAddr, `SDL_A_FAULTCODE):
        rdMux = {9'h000, faultOut.code, 2'h0, faultOut.value};
      hit(s_q.aAddr, `SDL_A_FAULTTIME): rdMux = {11'h000, faultOut.runHours};
      hit(s_q.aAddr, `SDL_A_STATUS):
        rdMux = {12'h000, faultFill, 3'h0, snapFill, 5'h00, s_q.snap};
      // selector reads back as no clear
      default: rdMux = '0;
    endcase
  end

  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.motorPrev = motorRunning;
    s_d.failPrev = powerFail;
    // 1 ms prescaler and wall clock
    s_d.tick = tickNow ? '0 : s_q.tick + 1'b1;
    if (tickNow)
    begin
      if (s_q.wallMs == MW'(TENTH_MS - 1))
      begin
        s_d.wallMs = '0;
        s_d.wallTenth = hourEnd ? 4'h0 : s_q.wallTenth + 4'h1;
      end
      else
      begin
        s_d.wallMs = s_q.wallMs + 1'b1;
      end
    end
    // operating hours: no clear path exists
    if (tickNow && converterOn)
    begin
      if (s_q.opMs == MW'(TENTH_MS - 1))
      begin
        s_d.opMs = '0;
        if (s_q.opHours < HOURS_MAX)
        begin
          s_d.opHours = s_q.opHours + 21'h000001;
        end
      end
      else
      begin
        s_d.opMs = s_q.opMs + 1'b1;
      end
    end
    // run hours
    if (tickNow && motorRunning)
    begin
      if (s_q.runMs == MW'(TENTH_MS - 1))
      begin
        s_d.runMs = '0;
        if (s_q.runHours < HOURS_MAX)
        begin
          s_d.runHours = s_q.runHours + 21'h000001;
        end
      end
      else
      begin
        s_d.runMs = s_q.runMs + 1'b1;
      end
    end
    if (runClr)
    begin
      s_d.runHours = '0;
      s_d.runMs = '0;
    end
    // energy: watt-ms summed over the hour, then counted out one kWh a cycle;
    // the drain keeps a divider out of the path at the cost of a few cycles
    if (tickNow)
    begin
      s_d.hourSum = s_q.hourSum + {24'h000000, outputPower};
    end
    s_d.residue = drain ? s_q.residue - KWH : s_q.residue;
    if (drain)
    begin
      s_d.energy = s_q.energy + 32'h00000001;
    end
    if (hourEnd)
    begin
      s_d.residue = s_d.residue + s_d.hourSum;
      s_d.hourSum = '0;
    end
    if (energyClr)
    begin
      s_d.energy = '0;
      s_d.residue = '0;
      s_d.hourSum = '0;
    end
    // hourly and power-loss save request
    s_d.persist = hourEnd || (powerFail && !s_q.failPrev);
    // event counters
    s_d.cutIns = bump(s_q.cutIns, supplyApplied);
    s_d.overTemps = bump(s_q.overTemps, overtempEvent);
    s_d.overVolts = bump(s_q.overVolts, overvoltEvent && overvoltAlarm);
    // snapshot logger mode
    case (s_q.snap)
      SNAP_IDLE:
      begin
        if (startCmd)
        begin
          s_d.snap = SNAP_RUN;
          s_d.snapMs = '0;
        end
      end
      SNAP_RUN:
      begin
        if (tripEvent || motorStop)
        begin
          s_d.snap = SNAP_HOLD;
        end
        else if (tickNow)
        begin
          s_d.snapMs = snapWr ? '0 : s_q.snapMs + 1'b1;
        end
      end
      SNAP_HOLD:
      begin
        // a new start resumes pushing over the kept entries
        if (startCmd)
        begin
          s_d.snap = SNAP_RUN;
          s_d.snapMs = '0;
        end
      end
      default: s_d.snap = SNAP_IDLE;
    endcase
    // register writes, zero wait states
    if (busWr && hit(s_q.aAddr, `SDL_A_CTRL))
    begin
      s_d.ctrl = hwdata[15:0];
    end
    if (busWr && hit(s_q.aAddr, `SDL_A_INDEX))
    begin
      s_d.snapIdx = hwdata[4:0];
      s_d.faultIdx = hwdata[11:8];
    end
    // reads wait two cycles so the history word follows a fresh index
    if (s_q.aValid && !s_q.aWrite && s_q.rdCnt != 2'h2)
    begin
      s_d.rdCnt = s_q.rdCnt + 2'h1;
      if (s_q.rdCnt == 2'h1)
      begin
        s_d.rdata = rdMux;
      end
    end
    // address phase
    if (hready)
    begin
      s_d.aValid = hsel && htrans[1];
      s_d.aWrite = hwrite;
      s_d.aAddr = haddr[7:2];
      s_d.rdCnt = '0;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= RESET_STATE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs
  assign hreadyout = !(s_q.aValid && !s_q.aWrite && s_q.rdCnt != 2'h2);
  assign hrdata = s_q.rdata;
  assign hresp = 1'b0;
  assign driveControlWord = s_q.ctrl;
  assign persistStrobe = s_q.persist;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // read handshake steps and a trip while the log runs
  sequence readStart;
    s_q.aValid && !s_q.aWrite && s_q.rdCnt == 2'h0;
  endsequence
  sequence readAnswer;
    !hreadyout ##1 !hreadyout ##1 hreadyout;
  endsequence
  sequence tripInRun;
    tripEvent && s_q.snap == SNAP_RUN;
  endsequence

  chk_read_wait: assert property (readStart |-> readAnswer)
    else $error("read answer timing wrong");
  chk_cutin_count: assert property (
    supplyApplied && s_q.cutIns < EVT_MAX |=> s_q.cutIns == $past(s_q.cutIns) + 14'h0001)
    else $error("cut-in not counted");
  chk_event_saturate: assert property (
    s_q.overTemps == EVT_MAX |=> s_q.overTemps == EVT_MAX)
    else $error("overtemp counter wrapped");
  chk_overtemp_count: assert property (
    overtempEvent && s_q.overTemps < EVT_MAX |=> s_q.overTemps != $past(s_q.overTemps))
    else $error("overtemp not counted");
  chk_overvolt_gate: assert property (
    !overvoltAlarm |=> s_q.overVolts == $past(s_q.overVolts))
    else $error("overvolt counted without alarm");
  chk_ophours_keep: assert property (
    1'b1 |=> s_q.opHours >= $past(s_q.opHours))
    else $error("operating hours went down");
  chk_run_clear: assert property (
    runClr |=> s_q.runHours == 21'h000000)
    else $error("run hours not cleared");
  chk_energy_clear: assert property (
    energyClr |=> s_q.energy == 32'h00000000 ##1 s_q.energy == 32'h00000000)
    else $error("energy not cleared");
  chk_energy_serial: assert property (
    busWr && !energyClr |=> s_q.energy >= $past(s_q.energy))
    else $error("bus cleared energy");
  chk_snap_freeze: assert property (
    tripInRun |=> s_q.snap == SNAP_HOLD && !snapWr)
    else $error("snapshot log not frozen");
  chk_snap_spacing: assert property (
    snapWr |=> !snapWr [*3])
    else $error("snapshots too close");
  chk_ctrl_bus_only: assert property (
    !(busWr && hit(s_q.aAddr, `SDL_A_CTRL)) |=> $stable(s_q.ctrl))
    else $error("control word changed off the bus");
  chk_fault_push: assert property (
    tripEvent && !manualInit && faultFill < 4'hA |=> faultFill == $past(faultFill) + 4'h1)
    else $error("fault entry not pushed");
endmodule // service_data_logger
`default_nettype wire

// [rtl/service_data_logger_defs.svh]
// Operation
// - count converter operating hours, never clearable
// - count motor run hours, persist hourly
// - accumulate kWh from hourly mean power
// - count supply cut-ins, 0 to 9999
// - count heat-sink overtemperature events
// - count overvoltage only while alarm active
// - snapshot log holds 20, 1 newest
// - after start, snapshot every 160 ms
// - trip or stop freezes snapshot log
// - input byte: terminal 16 is MSB
// - control and status words 16-bit unsigned
// - control word changed only by serial host
// - each trip records cause code 0-99
// - fault index 1 newest, 10 oldest
// - fault entry stores run hours at trip
// - fault entry stores trip value 0-9999
// - fault history cleared only by initialisation
// - panel selector 1 plus OK clears energy
// - serial host cannot select energy clear
// - panel selector plus OK clears run hours
`ifndef SERVICE_DATA_LOGGER_DEFS_SVH
`define SERVICE_DATA_LOGGER_DEFS_SVH
// timing
`define SDL_CLK_NS 4
`define SDL_MS_NS 1000000
`define SDL_TENTH_MS 360000
`define SDL_TENTHS_PER_HOUR 9
`define SDL_SNAP_MS 160
// limits and depths
`define SDL_HOURS_MAX 1300000
`define SDL_EVT_MAX 9999
`define SDL_CODE_MAX 99
`define SDL_SNAP_DEPTH 20
`define SDL_FAULT_DEPTH 10
`define SDL_W_PER_KW 1000
// register byte offsets
`define SDL_A_OPHOURS 8'h00
`define SDL_A_RUNHOURS 8'h04
`define SDL_A_ENERGY 8'h08
`define SDL_A_CUTINS 8'h0C
`define SDL_A_OVERTEMPS 8'h10
`define SDL_A_OVERVOLTS 8'h14
`define SDL_A_CTRL 8'h18
`define SDL_A_INDEX 8'h1C
`define SDL_A_SNAPWORDS 8'h20
`define SDL_A_SNAPINPUTS 8'h24
`define SDL_A_FAULTCODE 8'h28
`define SDL_A_FAULTTIME 8'h2C
`define SDL_A_STATUS 8'h30
`define SDL_A_CLRSEL 8'h34
`endif

// [rtl/sdl_pkg.sv]
package sdl_pkg;
  // snapshot logger modes, one-hot
  typedef enum logic [2:0] {
    SNAP_IDLE = 3'b001,
    SNAP_RUN = 3'b010,
    SNAP_HOLD = 3'b100
  } snap_state_t;
  // one snapshot entry
  typedef struct packed {
    logic [7:0] loggedInputBits;
    logic [15:0] controlWord;
    logic [15:0] loggedStateWord;
  } snap_entry_t;
  // one fault history entry
  typedef struct packed {
    logic [6:0] code;
    logic [13:0] value;
    logic [20:0] runHours;
  } fault_entry_t;
endpackage

// [rtl/log_memory.sv]
`timescale 1ns/100ps
`default_nettype none
// rolling history, read by age: index 1 is the newest entry
module log_memory #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 20,
  parameter int AW = 5
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // write side
  input wire logic clear,
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  // read side
  input wire logic [AW-1:0] rdIndex,
  output logic [WIDTH-1:0] rdData,
  output logic [AW-1:0] fill
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] ptr;
    logic [AW-1:0] fill;
    logic [WIDTH-1:0] rd;
  } mem_state_t;
  mem_state_t m_q, m_d;
  logic [AW:0] slot;
  // a ring with a moving head avoids shifting every word on each push
  always_comb
  begin
    m_d = m_q;
    slot = {1'b0, m_q.ptr} + (AW+1)'(DEPTH) - {1'b0, rdIndex};
    if (slot >= (AW+1)'(DEPTH))
    begin
      slot = slot - (AW+1)'(DEPTH);
    end
    // unwritten or out-of-range index reads as zero
    if (rdIndex == '0 || rdIndex > m_q.fill)
    begin
      m_d.rd = '0;
    end
    else
    begin
      m_d.rd = m_q.mem[slot[AW-1:0]];
    end
    // clear first, so a write in the same cycle survives it
    if (clear)
    begin
      m_d.ptr = '0;
      m_d.fill = '0;
    end
    if (wrEn)
    begin
      m_d.mem[m_d.ptr] = wrData;
      m_d.ptr = (m_d.ptr == AW'(DEPTH-1)) ? '0 : m_d.ptr + 1'b1;
      if (m_d.fill != AW'(DEPTH))
      begin
        m_d.fill = m_d.fill + 1'b1;
      end
    end
  end
  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      m_q <= '0;
    end
    else
    begin
      m_q <= m_d;
    end
  end
  assign rdData = m_q.rd;
  assign fill = m_q.fill;
endmodule // log_memory
`default_nettype wire

// [verification/panel_model.sv]
`timescale 1ns/100ps
`default_nettype none
// operator panel: selector levels plus a one-cycle OK key
module panel_model
(
  // clock
  input wire logic clk,
  // panel outputs
  output var logic energyClearSelect,
  output var logic runClearSelect,
  output var logic panelOk
);
  // idle panel: nothing selected, key up
  initial
  begin
    energyClearSelect = 1'b0;
    runClearSelect = 1'b0;
    panelOk = 1'b0;
  end
  // selector settles a cycle before the key, held across it
  task automatic press(input logic e, input logic r);
    energyClearSelect <= e;
    runClearSelect <= r;
    @(posedge clk);
    panelOk <= 1'b1;
    @(posedge clk);
    panelOk <= 1'b0;
    energyClearSelect <= 1'b0;
    runClearSelect <= 1'b0;
    @(posedge clk);
  endtask
endmodule // panel_model
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "service_data_logger_defs.svh"
module tb;
  // clock, reset and bus
  logic clk, reset, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  // drive side
  logic converterOn, motorRunning, supplyApplied, powerFail, overtempEvent;
  logic overvoltEvent, overvoltAlarm, startCmd, tripEvent, manualInit, persistStrobe;
  logic energyClearSelect, runClearSelect, panelOk;
  logic [15:0] outputPower, stateWord, tripValue, driveControlWord;
  logic [7:0] terminalIn;
  logic [6:0] tripCode;
  // bookkeeping
  int fail_count, compares;
  logic [31:0] rh, v;
  // short counts so an hour is 160 cycles and a snapshot 12
  service_data_logger #(.TICK_CYCLES(4), .TENTH_MS(4), .SNAP_MS(3)) uut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .converterOn(converterOn), .motorRunning(motorRunning),
    .supplyApplied(supplyApplied), .powerFail(powerFail),
    .overtempEvent(overtempEvent), .overvoltEvent(overvoltEvent),
    .overvoltAlarm(overvoltAlarm), .outputPower(outputPower), .startCmd(startCmd),
    .terminalIn(terminalIn), .stateWord(stateWord), .tripEvent(tripEvent),
    .tripCode(tripCode), .tripValue(tripValue), .energyClearSelect(energyClearSelect),
    .runClearSelect(runClearSelect), .panelOk(panelOk), .manualInit(manualInit),
    .driveControlWord(driveControlWord), .persistStrobe(persistStrobe));
  // operator panel on the far side
  panel_model panel (.clk(clk), .energyClearSelect(energyClearSelect),
    .runClearSelect(runClearSelect), .panelOk(panelOk));
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // verdict and end of run, the one place the run stops
  task automatic report_and_stop();
    $display("counts: compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // word comparison
  task automatic check32(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // wait for hready at a rising edge; a stuck slave ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
    begin
      $display("mismatch hready expected 1 seen %b", hreadyout);
      fail_count++;
      report_and_stop();
    end
  endtask
  // one single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  // register write, ignoring read data
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask
  // register read against an expected word
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] t;
    bus(1'b0, a, 32'h00000000, t);
    check32(nm, e, t);
  endtask
  // n one-cycle pulses on one event input, chosen by index
  task automatic pulse(input int w, input int n);
    repeat (n)
    begin
      {manualInit, tripEvent, startCmd, overvoltEvent, overtempEvent, supplyApplied} <=
        6'h01 << w;
      @(posedge clk);
      {manualInit, tripEvent, startCmd, overvoltEvent, overtempEvent, supplyApplied} <=
        6'h00;
      @(posedge clk);
    end
  endtask
  // main sequence
  initial
  begin
    fail_count = 0;
    compares = 0;
    reset = 1'b1;
    {hsel, hwrite, converterOn, motorRunning, supplyApplied, powerFail} = 6'h00;
    {overtempEvent, overvoltEvent, overvoltAlarm, startCmd, tripEvent, manualInit} = 6'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    outputPower = 16'h1000;
    {stateWord, tripValue} = 32'h0;
    terminalIn = 8'h00;
    tripCode = 7'h00;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // every register empty after reset, status shows idle, plus an unmapped place
    for (int a = 0; a <= 56; a += 4)
      rd_chk(a[7:0], (a == 48) ? 32'h00000001 : 32'h00000000, "reset value");
    wr(8'h38, 32'hFFFFFFFF);
    rd_chk(8'h38, 32'h00000000, "unmapped");
    $display("test reset done");
    // control word only from the serial side, then snapshots while running
    converterOn <= 1'b1;
    wr(`SDL_A_CTRL, 32'h0000BEEF);
    // the write lands at the edge the task returns on; look one edge later
    @(posedge clk);
    check32("control pin", 32'h0000BEEF, {16'h0000, driveControlWord});
    terminalIn <= 8'h05;
    stateWord <= 16'h1234;
    motorRunning <= 1'b1;
    pulse(3, 1);
    repeat (300) @(posedge clk);
    stateWord <= 16'h5678;
    // 14 cycles hold one or two pushes, never three
    repeat (14) @(posedge clk);
    motorRunning <= 1'b0;
    stateWord <= 16'h9ABC;
    repeat (40) @(posedge clk);
    rd_chk(`SDL_A_STATUS, 32'h00001404, "frozen full log");
    wr(`SDL_A_INDEX, 32'h00000001);
    rd_chk(`SDL_A_SNAPWORDS, 32'hBEEF5678, "newest words");
    rd_chk(`SDL_A_SNAPINPUTS, 32'h000000A0, "input bits");
    wr(`SDL_A_INDEX, 32'h00000003);
    rd_chk(`SDL_A_SNAPWORDS, 32'hBEEF1234, "older words");
    wr(`SDL_A_INDEX, 32'h00000015);
    rd_chk(`SDL_A_SNAPWORDS, 32'h00000000, "past depth");
    $display("test snapshot done");
    // event counters, alarm gating and saturation
    pulse(0, 3);
    rd_chk(`SDL_A_CUTINS, 32'h00000003, "cut-ins");
    pulse(2, 2);
    overvoltAlarm <= 1'b1;
    pulse(2, 1);
    overvoltAlarm <= 1'b0;
    rd_chk(`SDL_A_OVERVOLTS, 32'h00000001, "overvolts");
    pulse(1, 2);
    rd_chk(`SDL_A_OVERTEMPS, 32'h00000002, "overtemps");
    pulse(1, 9999);
    rd_chk(`SDL_A_OVERTEMPS, 32'h0000270F, "overtemp limit");
    $display("test counters done");
    // two trips, the first with out-of-range code and value
    bus(1'b0, `SDL_A_RUNHOURS, 32'h00000000, rh);
    check32("run hours counted", 32'h00000001, {31'h0, rh != 32'h0});
    tripCode <= 7'h78;
    tripValue <= 16'h4E20;
    // restart logging so the first trip lands while the log is running
    pulse(3, 1);
    pulse(4, 1);
    tripCode <= 7'h05;
    tripValue <= 16'h0007;
    pulse(4, 1);
    wr(`SDL_A_INDEX, 32'h00000101);
    rd_chk(`SDL_A_FAULTCODE, 32'h00050007, "newest fault");
    rd_chk(`SDL_A_FAULTTIME, rh, "fault run hours");
    wr(`SDL_A_INDEX, 32'h00000201);
    rd_chk(`SDL_A_FAULTCODE, 32'h0063270F, "older fault");
    $display("test faults done");
    // panel clears, serial clear refused, fault history survives them
    panel.press(1'b0, 1'b0);
    rd_chk(`SDL_A_RUNHOURS, rh, "no clear");
    panel.press(1'b0, 1'b1);
    rd_chk(`SDL_A_RUNHOURS, 32'h00000000, "run hours cleared");
    bus(1'b0, `SDL_A_OPHOURS, 32'h00000000, v);
    check32("op hours kept", 32'h00000001, {31'h0, v != 32'h0});
    wr(`SDL_A_CLRSEL, 32'h00000001);
    rd_chk(`SDL_A_CLRSEL, 32'h00000000, "serial clear");
    check32("bus response", 32'h00000000, {31'h0, hresp});
    bus(1'b0, `SDL_A_ENERGY, 32'h00000000, v);
    check32("energy counted", 32'h00000001, {31'h0, v != 32'h0});
    panel.press(1'b1, 1'b0);
    rd_chk(`SDL_A_ENERGY, 32'h00000000, "energy cleared");
    rd_chk(`SDL_A_STATUS, 32'h00021404, "faults kept");
    pulse(5, 1);
    rd_chk(`SDL_A_STATUS, 32'h00001404, "faults emptied");
    $display("test clears done");
    // save request on loss of supply
    powerFail <= 1'b1;
    for (int n = 0; n < 8 && persistStrobe !== 1'b1; n++)
      @(posedge clk);
    check32("persist strobe", 32'h00000001, {31'h0, persistStrobe});
    powerFail <= 1'b0;
    $display("test persist done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
